/* quad_dac_pkg.sv */
// Shared constants for the quad DAC serial load block
`default_nettype none
package quad_dac_pkg;
    localparam int WORD_BITS = 16;
    localparam int DATA_BITS = 12;
    localparam int CHANNELS = 4;
    localparam int ADDR_HI_POS = 15;
    localparam int ADDR_LO_POS = 14;
    localparam int DATA_MSB_POS = 11;
    localparam int FIFO_DEPTH = 4;
    localparam int SYNC_STAGES = 3;
    localparam logic [11:0] CODE_ZERO = 12'h000;
    localparam logic [11:0] CODE_MID = 12'h800;
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [1:0] ADDR_CH_A = 2'h0;
    localparam logic [1:0] ADDR_CH_B = 2'h1;
    localparam logic [1:0] ADDR_CH_C = 2'h2;
    localparam logic [1:0] ADDR_CH_D = 2'h3;
endpackage
`default_nettype wire

/* quad_dac_serial_load.sv */
// Serial word capture, load crossing, word FIFO and four channel code registers
// Operation
// - With select low, each rising serial clock shifts serial data into the 16-bit register.
// - Words arrive high address bit first, data bit 0 last.
// - Word is two address bits, two fill bits, then twelve data bits.
// - Load strobe after 16 bits moves the shift register onto the internal bus.
// - Address 00/01/10/11 writes channel A/B/C/D.
// - Serial clock ORed with select; either rising edge while the other is low shifts.
// - Select rising while clock low shifts one spurious bit.
// - Clear loads all four channels with zero or midscale.
// - Clear is independent of serial clock and select.
// - Channels keep the cleared value until the next load.
// - Shift register survives clear; later load writes the old word.
// - Channel codes are straight binary across the reference span.
// - Clear level select high gives 0x800, low gives 0x000.
// - Load acts on its falling edge, path stays transparent while low.
// - Select high ignores serial data, no shifting.
`default_nettype none

module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = (p == LAST_PTR) ? '0 : AW'(p + 1'b1);
    endfunction

    assign in_ready = (count_reg != FULL_COUNT);
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= next_ptr(wr_ptr_reg);
            end
            if (pop) begin
                rd_ptr_reg <= next_ptr(rd_ptr_reg);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
        end
    end
endmodule

module quad_dac_serial_load #(
    parameter int DEPTH = quad_dac_pkg::FIFO_DEPTH
) (
    // System clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial link from the host
    input wire logic serial_clk,
    input wire logic select_n,
    input wire logic serial_data_in,
    input wire logic load_strobe_n,
    // Clear control
    input wire logic clear_n,
    input wire logic clear_level_select,
    // Channel codes, straight binary
    output logic [quad_dac_pkg::DATA_BITS-1:0] channel_code_a,
    output logic [quad_dac_pkg::DATA_BITS-1:0] channel_code_b,
    output logic [quad_dac_pkg::DATA_BITS-1:0] channel_code_c,
    output logic [quad_dac_pkg::DATA_BITS-1:0] channel_code_d
);
    import quad_dac_pkg::*;

    wire logic shift_clk;
    logic [WORD_BITS-1:0] shift_reg;
    logic [WORD_BITS-1:0] word_meta_reg;
    logic [WORD_BITS-1:0] word_sync_reg;
    logic [WORD_BITS-1:0] last_word_reg;
    logic [SYNC_STAGES-1:0] load_sync_reg;
    logic [SYNC_STAGES-1:0] clear_sync_reg;
    logic [SYNC_STAGES-1:0] level_sync_reg;
    logic load_level_reg;
    logic clear_level_reg;
    logic mid_level_reg;
    logic load_next;
    logic load_fall;
    logic push_pending_reg;
    logic push_want;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [WORD_BITS-1:0] fifo_out_data;
    logic [DATA_BITS-1:0] clear_code;
    logic [1:0] pop_addr;
    logic pop;

    // Filtered level: accept a change once stages two and three agree
    function automatic logic filt(input logic [SYNC_STAGES-1:0] s, input logic old);
        filt = (s[1] == s[2]) ? s[2] : old;
    endfunction

    // Link domain: select high holds the shift clock high
    assign shift_clk = serial_clk | select_n;

    // No reset or clear here so a held word survives a clear
    always_ff @(posedge shift_clk) begin
        shift_reg <= {shift_reg[WORD_BITS-2:0], serial_data_in};
    end

    // Word is resampled every clock through two stages, so it has settled before the filtered load fall
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_meta_reg <= WORD_RESET;
            word_sync_reg <= WORD_RESET;
        end else begin
            word_meta_reg <= shift_reg;
            word_sync_reg <= word_meta_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_sync_reg <= '1;
            clear_sync_reg <= '1;
            level_sync_reg <= '0;
        end else begin
            load_sync_reg <= {load_sync_reg[1:0], load_strobe_n};
            clear_sync_reg <= {clear_sync_reg[1:0], clear_n};
            level_sync_reg <= {level_sync_reg[1:0], clear_level_select};
        end
    end

    assign load_next = filt(load_sync_reg, load_level_reg);
    assign load_fall = load_level_reg & ~load_next;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_level_reg <= 1'b1;
            clear_level_reg <= 1'b1;
            mid_level_reg <= 1'b0;
        end else begin
            load_level_reg <= load_next;
            clear_level_reg <= filt(clear_sync_reg, clear_level_reg);
            mid_level_reg <= filt(level_sync_reg, mid_level_reg);
        end
    end

    // Push on the falling edge, and again for any change while transparent
    assign push_want = load_fall | push_pending_reg
        | (~load_level_reg & (word_sync_reg != last_word_reg));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            push_pending_reg <= 1'b0;
            last_word_reg <= WORD_RESET;
        end else begin
            push_pending_reg <= push_want & ~fifo_in_ready;
            if (push_want && fifo_in_ready) begin
                last_word_reg <= word_sync_reg;
            end
        end
    end

    word_fifo #(
        .WIDTH(WORD_BITS),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(push_want),
        .in_ready(fifo_in_ready),
        .in_data(word_sync_reg),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Drain stalls while clear is held so the cleared value wins
    assign fifo_out_ready = clear_level_reg;
    assign pop = fifo_out_valid & fifo_out_ready;
    assign pop_addr = {fifo_out_data[ADDR_HI_POS], fifo_out_data[ADDR_LO_POS]};
    assign clear_code = mid_level_reg ? CODE_MID : CODE_ZERO;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            channel_code_a <= CODE_RESET;
            channel_code_b <= CODE_RESET;
            channel_code_c <= CODE_RESET;
            channel_code_d <= CODE_RESET;
        end else if (!clear_level_reg) begin
            channel_code_a <= clear_code;
            channel_code_b <= clear_code;
            channel_code_c <= clear_code;
            channel_code_d <= clear_code;
        end else if (pop) begin
            // Fill bits 13:12 are never read
            unique case (pop_addr)
                ADDR_CH_A: channel_code_a <= fifo_out_data[DATA_MSB_POS:0];
                ADDR_CH_B: channel_code_b <= fifo_out_data[DATA_MSB_POS:0];
                ADDR_CH_C: channel_code_c <= fifo_out_data[DATA_MSB_POS:0];
                ADDR_CH_D: channel_code_d <= fifo_out_data[DATA_MSB_POS:0];
            endcase
        end
    end
endmodule
`default_nettype wire

/* quad_dac_pkg_end.sv */
// Intentionally empty companion file
`default_nettype none
`default_nettype wire

/* quad_dac_serial_load_sva.sv */
// Checker for channel code behaviour
`default_nettype none
module quad_dac_serial_load_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link and controls
    input wire logic serial_clk,
    input wire logic select_n,
    input wire logic serial_data_in,
    input wire logic load_strobe_n,
    input wire logic clear_n,
    input wire logic clear_level_select,
    // Channel codes
    input wire logic [11:0] channel_code_a,
    input wire logic [11:0] channel_code_b,
    input wire logic [11:0] channel_code_c,
    input wire logic [11:0] channel_code_d
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_clear_zero: assert property ((!clear_n && !clear_level_select) [*6] |->
        (channel_code_a | channel_code_b | channel_code_c | channel_code_d) == 12'h000) else $error("no zero");
    a_clear_mid: assert property ((!clear_n && clear_level_select) [*6] |->
        channel_code_a == 12'h800 && channel_code_d == 12'h800) else $error("no midscale");
    a_clear_all: assert property (!clear_n [*6] |-> channel_code_a == channel_code_b &&
        channel_code_b == channel_code_c && channel_code_c == channel_code_d) else $error("clear partial");
    a_hold_quiet: assert property ((load_strobe_n && clear_n) [*8] |-> $stable(channel_code_a) &&
        $stable(channel_code_b) && $stable(channel_code_c) && $stable(channel_code_d)) else $error("code moved");
    a_keep_cleared: assert property (!clear_n [*6] ##1 (clear_n && load_strobe_n) [*8] |->
        channel_code_b == $past(channel_code_b, 8)) else $error("clear lost");
    a_one_chan_a: assert property (clear_n [*8] ##0 $changed(channel_code_a) |->
        $stable(channel_code_b) && $stable(channel_code_c) && $stable(channel_code_d)) else $error("two moved");
    a_one_chan_d: assert property (clear_n [*8] ##0 $changed(channel_code_d) |->
        $stable(channel_code_a) && $stable(channel_code_b) && $stable(channel_code_c)) else $error("two moved");
    a_load_lat: assert property ($fell(load_strobe_n) && clear_n |-> ##[4:9] ($changed(channel_code_a) ||
        $changed(channel_code_b) || $changed(channel_code_c) || $changed(channel_code_d))) else $error("no write");
endmodule
bind quad_dac_serial_load quad_dac_serial_load_chk i_chk (.clk, .rst, .serial_clk, .select_n, .serial_data_in,
    .load_strobe_n, .clear_n, .clear_level_select, .channel_code_a, .channel_code_b, .channel_code_c, .channel_code_d);
`default_nettype wire

/* host_serial_port.sv */
// Host serial port model for the link and load strobe
`default_nettype none
module host_serial_port (
    // Link and load
    output var logic serial_clk,
    output var logic select_n,
    output var logic serial_data_in,
    output var logic load_strobe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        serial_clk = 1'b1;
        select_n = 1'b1;
        serial_data_in = 1'b0;
        load_strobe_n = 1'b1;
    end
    // Extra set: select rises with clock low
    task automatic send(input logic [15:0] w, input bit extra);
        select_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            #80 serial_clk = 1'b0;
            serial_data_in = w[i];
            #80 serial_clk = 1'b1;
        end
        #80 serial_clk = !extra;
        #80 select_n = 1'b1;
        // Data holds past a spurious edge from select
        #80 serial_data_in = !serial_data_in;
        serial_clk = 1'b1;
    endtask
    task automatic noise();
        repeat (4) begin
            #80 serial_clk = 1'b0;
            serial_data_in = !serial_data_in;
            #80 serial_clk = 1'b1;
        end
    endtask
    task automatic load();
        #40 load_strobe_n = 1'b0;
        #40 load_strobe_n = 1'b1;
        #40;
    endtask
endmodule
`default_nettype wire

/* quad_dac_serial_load_tb_top.sv */
// Self-checking bench for the quad DAC serial load block
`default_nettype none
module quad_dac_serial_load_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import quad_dac_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clear_n = 1'b1;
    logic clear_level_select = 1'b0;
    wire logic serial_clk, select_n, serial_data_in, load_strobe_n;
    logic [11:0] channel_code_a, channel_code_b, channel_code_c, channel_code_d;
    logic [11:0] exp_code [4] = '{default: 12'h000};
    logic [15:0] held;
    logic [31:0] seed = 32'ha2bc;
    int err_total = 0;
    int checks = 0;
    always #2.5 clk = ~clk;
    host_serial_port i_host_serial_port (.serial_clk, .select_n, .serial_data_in, .load_strobe_n);
    quad_dac_serial_load i_quad_dac_serial_load (.clk, .rst, .serial_clk, .select_n, .serial_data_in,
        .load_strobe_n, .clear_n, .clear_level_select, .channel_code_a, .channel_code_b, .channel_code_c,
        .channel_code_d);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [11:0] got, input logic [11:0] want);
        checks++;
        if (got !== want) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic cmp_all();
        repeat (12) @(negedge clk);
        chk(channel_code_a, exp_code[0]);
        chk(channel_code_b, exp_code[1]);
        chk(channel_code_c, exp_code[2]);
        chk(channel_code_d, exp_code[3]);
    endtask
    // Odd data keeps each write visible
    task automatic xfer(input logic [1:0] addr, input bit extra);
        seed = lfsr(seed);
        held = {addr, seed[13:12], seed[11:0] | 12'h001};
        i_host_serial_port.send(held, extra);
        if (extra) held = {held[14:0], held[0]};
        i_host_serial_port.load();
        exp_code[held[15:14]] = held[11:0];
        cmp_all();
    endtask
    task automatic clear(input logic lvl);
        clear_level_select = lvl;
        repeat (6) @(negedge clk);
        clear_n = 1'b0;
        foreach (exp_code[i]) exp_code[i] = lvl ? CODE_MID : CODE_ZERO;
        cmp_all();
        clear_n = 1'b1;
        cmp_all();
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        #7.3;
        for (int a = 0; a < 4; a++) xfer(a[1:0], 1'b0);
        $display("test address decode done");
        clear(1'b0);
        clear(1'b1);
        i_host_serial_port.noise();
        i_host_serial_port.load();
        exp_code[held[15:14]] = held[11:0];
        cmp_all();
        $display("test clear done");
        seed = lfsr(seed);
        held = {ADDR_CH_D, seed[13:12], seed[11:0] | 12'h001};
        i_host_serial_port.send(held, 1'b0);
        repeat (6) @(negedge clk);
        clear_n = 1'b0;
        // Load during clear waits in the FIFO until clear ends
        i_host_serial_port.load();
        exp_code[3] = CODE_MID;
        cmp_all();
        clear_n = 1'b1;
        exp_code[3] = held[11:0];
        cmp_all();
        $display("test queued load done");
        xfer(2'h2, 1'b1);
        $display("test spurious bit done");
        complete_run();
    end
endmodule
`default_nettype wire
